/* File: cpu_fifo_port_cfg.svh */
// Constants of the CPU-style FIFO port: widths, depths, status layout
`ifndef CPU_FIFO_PORT_CFG_SVH
`define CPU_FIFO_PORT_CFG_SVH

`define CFP_DATA_W          8
`define CFP_RX_DEPTH        1024
`define CFP_SYNC_STAGES     2
`define CFP_ADDR_DATA       1'b0
`define CFP_ADDR_STATUS     1'b1
`define CFP_STAT_TXAVAIL    0
`define CFP_STAT_RXFULL     1
`define CFP_STAT_FLUSH      2
`define CFP_STAT_MODE       3
`define CFP_BYTE_RESET      8'h00
`define CFP_PIN_IDLE        1'b1

`endif

/* File: cpu_fifo_port_pkg.sv */
// Types shared by the CPU-style FIFO port
package cpu_fifo_port_pkg;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } access_state_t;

endpackage

/* File: pin_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [63:0] RESET_VAL = 64'h0
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  initial
  begin
    if (WIDTH < 1 || WIDTH > 64)
      $error("pin_sync: WIDTH must be 1 to 64");
  end

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      meta_reg <= RESET_VAL[WIDTH-1:0];
      sync_o   <= RESET_VAL[WIDTH-1:0];
    end
    else
    begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // pin_sync

/* File: cpu_fifo_port.sv */
// CPU-style FIFO port: strobe-driven byte bus to the USB-side buffers
//
// Behaviour
// R1 - Shared 8-bit data bus: device drives on reads, processor on writes.
// R2 - Accesses are served only while the unit select input is low.
// R3 - Read strobe low makes the device present a byte on the bus.
// R4 - Write strobe low with a byte makes the device store that byte.
// R5 - Send-now strobe while suspended and wakeup enabled requests a USB resume.
// R6 - Send-now strobe in normal operation flushes receive data on next bulk-IN.
// R7 - Port works only when configuration memory selects CPU FIFO mode.
// R8 - Written bytes wait in a 1-kilobyte receive buffer for the host.
// R9 - Transfer needs select held, address stable; bus released when no read.
`timescale 1ns/1ps
`include "cpu_fifo_port_cfg.svh"
module cpu_fifo_port #(
  parameter int RX_DEPTH = `CFP_RX_DEPTH,
  parameter int DATA_W   = `CFP_DATA_W
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Processor pins
  input  wire logic              cs_n_i,
  input  wire logic              port_address_bit_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_n_i,
  input  wire logic [DATA_W-1:0] cpu_data_bus_i,
  output logic      [DATA_W-1:0] cpu_data_bus_o,
  output logic                   cpu_data_bus_oe_o,
  input  wire logic              send_now_wake_n_i,
  // Configuration and USB core status
  input  wire logic              cpu_fifo_mode_i,
  input  wire logic              remote_wake_en_i,
  input  wire logic              power_enable_n_i,
  output logic                   mode_active_o,
  output logic                   resume_req_o,
  output logic                   flush_o,
  input  wire logic              bulk_in_req_i,
  // Host-to-processor byte stream
  input  wire logic              usb_tx_valid_i,
  input  wire logic [DATA_W-1:0] usb_tx_data_i,
  output logic                   usb_tx_ready_o,
  // Processor-to-host receive buffer drain
  output logic                   usb_rx_valid_o,
  output logic      [DATA_W-1:0] usb_rx_data_o,
  input  wire logic              usb_rx_pop_i,
  output logic [$clog2(RX_DEPTH):0] rx_level_o
);

  localparam int PW = $clog2(RX_DEPTH);

  initial
  begin
    if (DATA_W != `CFP_DATA_W)
      $error("cpu_fifo_port: data bus is fixed at 8 bits");
    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
      $error("cpu_fifo_port: RX_DEPTH must be a power of two");
  end

  //--------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------
  logic [4:0]        ctl_s;
  logic [DATA_W-1:0] data_s;
  logic              cs_n_s;
  logic              a0_s;
  logic              rd_n_s;
  logic              wr_n_s;
  logic              send_now_wake_n_n_s;

  pin_sync #(
    .WIDTH     (5),
    .RESET_VAL ({59'h0, 5'h1f})
  ) u_ctl_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  ({cs_n_i, port_address_bit_i, rd_n_i, wr_n_i, send_now_wake_n_i}),
    .sync_o   (ctl_s)
  );

  pin_sync #(
    .WIDTH     (DATA_W),
    .RESET_VAL (64'h0)
  ) u_data_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (cpu_data_bus_i),
    .sync_o   (data_s)
  );

  assign cs_n_s   = ctl_s[4];
  assign a0_s     = ctl_s[3];
  assign rd_n_s   = ctl_s[2];
  assign wr_n_s   = ctl_s[1];
  assign send_now_wake_n_n_s = ctl_s[0];

  //--------------------------------------------------------------
  // Mode strap, caught once after reset release
  //--------------------------------------------------------------
  logic strap_done_reg;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      strap_done_reg <= 1'b0;
      mode_active_o  <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      mode_active_o  <= cpu_fifo_mode_i; // R7
    end
  end

  //--------------------------------------------------------------
  // Access sequencer
  //--------------------------------------------------------------
  cpu_fifo_port_pkg::access_state_t state_reg;
  logic              a0_lat_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              tx_hold_valid_reg;
  logic [DATA_W-1:0] tx_hold_reg;
  logic              rx_full;
  logic              read_start;
  logic              tx_pop;
  logic              rx_push;
  logic [DATA_W-1:0] status_byte;

  // Start of a read needs select low and mode active
  assign read_start = (state_reg == cpu_fifo_port_pkg::ACC_IDLE) && mode_active_o
                      && !cs_n_s && !rd_n_s; // R2 R3
  assign tx_pop     = read_start && (a0_s == `CFP_ADDR_DATA) && tx_hold_valid_reg;
  // Write commits at strobe release, select still low, address unchanged
  assign rx_push    = (state_reg == cpu_fifo_port_pkg::ACC_WRITE) && wr_n_s && !cs_n_s
                      && (a0_s == a0_lat_reg) && (a0_lat_reg == `CFP_ADDR_DATA)
                      && !rx_full; // R4 R9

  always_comb
  begin
    status_byte                    = `CFP_BYTE_RESET;
    status_byte[`CFP_STAT_TXAVAIL] = tx_hold_valid_reg;
    status_byte[`CFP_STAT_RXFULL]  = rx_full;
    status_byte[`CFP_STAT_FLUSH]   = flush_o;
    status_byte[`CFP_STAT_MODE]    = mode_active_o;
  end

  // Bus cycle state
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state_reg  <= cpu_fifo_port_pkg::ACC_IDLE;
      a0_lat_reg <= 1'b0;
      wdata_reg  <= `CFP_BYTE_RESET;
    end
    else
    begin
      unique case (state_reg)
        cpu_fifo_port_pkg::ACC_IDLE:
        begin
          a0_lat_reg <= a0_s;
          if (read_start)
            state_reg <= cpu_fifo_port_pkg::ACC_READ;
          else if (mode_active_o && !cs_n_s && !wr_n_s) // R2 R4
          begin
            state_reg <= cpu_fifo_port_pkg::ACC_WRITE;
            wdata_reg <= data_s;
          end
        end
        cpu_fifo_port_pkg::ACC_READ:
        begin
          if (rd_n_s || cs_n_s)
            state_reg <= cpu_fifo_port_pkg::ACC_IDLE;
        end
        cpu_fifo_port_pkg::ACC_WRITE:
        begin
          // Data is sampled while the strobe stays low
          if (!wr_n_s)
            wdata_reg <= data_s;
          if (wr_n_s || cs_n_s) // R9
            state_reg <= cpu_fifo_port_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // Data bus drive, only during a read
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cpu_data_bus_o    <= `CFP_BYTE_RESET;
      cpu_data_bus_oe_o <= 1'b0;
    end
    else if (read_start)
    begin
      cpu_data_bus_oe_o <= 1'b1; // R1 R3
      cpu_data_bus_o    <= (a0_s == `CFP_ADDR_STATUS) ? status_byte :
                           (tx_hold_valid_reg ? tx_hold_reg : `CFP_BYTE_RESET);
    end
    else if (state_reg == cpu_fifo_port_pkg::ACC_READ && (rd_n_s || cs_n_s))
      cpu_data_bus_oe_o <= 1'b0; // R9
  end

  //--------------------------------------------------------------
  // Host-to-processor holding byte
  //--------------------------------------------------------------
  logic tx_take;
  logic tx_hold_next;

  assign tx_take      = usb_tx_valid_i && usb_tx_ready_o;
  assign tx_hold_next = tx_take || (tx_hold_valid_reg && !tx_pop);

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      tx_hold_valid_reg <= 1'b0;
      tx_hold_reg       <= `CFP_BYTE_RESET;
      usb_tx_ready_o    <= 1'b0;
    end
    else
    begin
      tx_hold_valid_reg <= tx_hold_next;
      usb_tx_ready_o    <= !tx_hold_next;
      if (tx_take)
        tx_hold_reg <= usb_tx_data_i;
    end
  end

  //--------------------------------------------------------------
  // Receive buffer, processor writes and USB side drains
  //--------------------------------------------------------------
  logic [DATA_W-1:0] rx_mem [RX_DEPTH];
  logic [PW:0]       wr_ptr_reg;
  logic [PW:0]       rd_ptr_reg;
  logic              rx_empty;
  logic              rx_load;

  assign rx_full  = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                    (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
  assign rx_empty = (wr_ptr_reg == rd_ptr_reg);
  // Show-ahead stage refills when empty or being popped
  assign rx_load  = !rx_empty && (!usb_rx_valid_o || usb_rx_pop_i);

  // Storage array
  always_ff @(posedge clk_i)
  begin
    if (rx_push)
      rx_mem[wr_ptr_reg[PW-1:0]] <= wdata_reg; // R8
  end

  // Pointers, output stage and fill level
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_reg     <= '0;
      rd_ptr_reg     <= '0;
      usb_rx_valid_o <= 1'b0;
      usb_rx_data_o  <= `CFP_BYTE_RESET;
      rx_level_o     <= '0;
    end
    else
    begin
      if (rx_push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1; // R8
      if (rx_load)
      begin
        rd_ptr_reg     <= rd_ptr_reg + 1'b1;
        usb_rx_data_o  <= rx_mem[rd_ptr_reg[PW-1:0]];
        usb_rx_valid_o <= 1'b1;
      end
      else if (usb_rx_pop_i)
        usb_rx_valid_o <= 1'b0;
      rx_level_o <= wr_ptr_reg - rd_ptr_reg + (PW + 1)'(rx_push) - (PW + 1)'(rx_load);
    end
  end

  //--------------------------------------------------------------
  // Send-now / wake strobe
  //--------------------------------------------------------------
  logic send_now_wake_n_prev_reg;
  logic send_now_wake_n_fall;

  assign send_now_wake_n_fall = send_now_wake_n_prev_reg && !send_now_wake_n_n_s && mode_active_o;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      send_now_wake_n_prev_reg <= `CFP_PIN_IDLE;
      resume_req_o  <= 1'b0;
      flush_o       <= 1'b0;
    end
    else
    begin
      send_now_wake_n_prev_reg <= send_now_wake_n_n_s;
      // One-cycle resume request while suspended
      resume_req_o  <= send_now_wake_n_fall && power_enable_n_i && remote_wake_en_i; // R5
      // Flush pending until next bulk-IN; a new strobe beats the clear
      if (send_now_wake_n_fall && !power_enable_n_i)
        flush_o <= 1'b1; // R6
      else if (bulk_in_req_i)
        flush_o <= 1'b0;
    end
  end

endmodule // cpu_fifo_port

/* File: cpu_fifo_port_properties.sv */
// Assertions on the CPU-style FIFO port pins
`timescale 1ns/1ps
module cpu_fifo_port_properties (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic cs_n_i,
  input  wire logic port_address_bit_i,
  input  wire logic rd_n_i,
  input  wire logic wr_n_i,
  input  wire logic send_now_wake_n_i,
  input  wire logic remote_wake_en_i,
  input  wire logic power_enable_n_i,
  input  wire logic bulk_in_req_i,
  input  wire logic usb_tx_valid_i,
  input  wire logic cpu_data_bus_oe_o,
  input  wire logic mode_active_o,
  input  wire logic resume_req_o,
  input  wire logic flush_o,
  input  wire logic usb_tx_ready_o,
  input  wire logic usb_rx_valid_o
);
  // --------------------------------
  // Pin-level properties
  // --------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_no_mode;
    !mode_active_o |-> !cpu_data_bus_oe_o;
  endproperty
  a_no_mode: assert property (p_no_mode) else $error("bus driven outside mode");
  property p_drive_cause;
    cpu_data_bus_oe_o |-> mode_active_o && !$past(cs_n_i, 3) && !$past(rd_n_i, 3);
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("bus driven without read");
  property p_release;
    cpu_data_bus_oe_o && ($past(rd_n_i, 2) || $past(cs_n_i, 2)) |=> !cpu_data_bus_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_resume;
    resume_req_o |-> $past(power_enable_n_i) && $past(remote_wake_en_i)
      && !$past(send_now_wake_n_i, 3) && $past(send_now_wake_n_i, 4) ##1 !resume_req_o;
  endproperty
  a_resume: assert property (p_resume) else $error("bad resume pulse");
  property p_flush_set;
    $rose(flush_o) |-> !$past(power_enable_n_i)
      && !$past(send_now_wake_n_i, 3) && $past(send_now_wake_n_i, 4);
  endproperty
  a_flush_set: assert property (p_flush_set) else $error("bad flush set");
  property p_flush_clr;
    flush_o && bulk_in_req_i && ($past(send_now_wake_n_i, 2) || !$past(send_now_wake_n_i, 3))
      |=> !flush_o;
  endproperty
  a_flush_clr: assert property (p_flush_clr) else $error("flush not cleared");
  property p_store;
    $rose(usb_rx_valid_o) |-> $past(wr_n_i, 4) && !$past(wr_n_i, 5)
      && !$past(cs_n_i, 5) && !$past(port_address_bit_i, 5);
  endproperty
  a_store: assert property (p_store) else $error("byte stored without write");
  property p_tx_take;
    $fell(usb_tx_ready_o) |-> $past(usb_tx_valid_i);
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("host byte taken without offer");
endmodule // cpu_fifo_port_properties

bind cpu_fifo_port cpu_fifo_port_properties i_cpu_fifo_port_properties (
  .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .port_address_bit_i(port_address_bit_i),
  .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .send_now_wake_n_i(send_now_wake_n_i),
  .remote_wake_en_i(remote_wake_en_i), .power_enable_n_i(power_enable_n_i),
  .bulk_in_req_i(bulk_in_req_i), .usb_tx_valid_i(usb_tx_valid_i),
  .cpu_data_bus_oe_o(cpu_data_bus_oe_o), .mode_active_o(mode_active_o),
  .resume_req_o(resume_req_o), .flush_o(flush_o), .usb_tx_ready_o(usb_tx_ready_o),
  .usb_rx_valid_o(usb_rx_valid_o));

/* File: cpu_proc_model.sv */
// Processor model driving the CPU-style FIFO port strobes
`timescale 1ns/1ps
module cpu_proc_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  output logic            cs_n_o,
  output logic            addr_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic [7:0]      bus_o
);
  logic [7:0] drv = 8'h00;
  logic       drv_en = 1'b0;
  // Wire level; a released bus shows the inverse of the last byte
  assign bus_o = dev_oe_i ? dev_data_i : (drv_en ? drv : ~drv);
  // Idle pins
  initial
  begin
    cs_n_o = 1'b1;
    addr_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
  end
  // One strobe cycle; select and address held around the whole pulse
  task automatic access(input logic wr, input logic cs_n, input logic a,
                        input logic [7:0] d, input int lo, output logic [7:0] q);
    cs_n_o = cs_n;
    addr_o = a;
    drv = d;
    drv_en = wr;
    @(posedge clk_i);
    #1;
    if (wr) wr_n_o = 1'b0;
    else rd_n_o = 1'b0;
    repeat (lo) @(posedge clk_i);
    #1;
    q = bus_o;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    cs_n_o = 1'b1;
    drv_en = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
endmodule // cpu_proc_model

/* File: cpu_fifo_port_bench.sv */
// Testbench of the CPU-style FIFO port
`timescale 1ns/1ps
`include "cpu_fifo_port_cfg.svh"
module cpu_fifo_port_bench;
  logic       clk_i = 0, resetn_i = 0, cs_n, addr, rd_n, wr_n, oe, snw = 1, mode = 1;
  logic       rwe = 1, pe_n = 1, bulk = 0, tx_v = 0, tx_rdy, rx_v, pop = 0, act, rsm, fl;
  logic       seen_oe = 0;
  logic [7:0] bus, dout, tx_d = 8'h00, rx_d, q, d;
  logic [4:0] lvl;
  logic [7:0] exp_q[$];
  int         failures = 0, n_compared = 0, resumes = 0, r0;

  always #12.5 clk_i = ~clk_i;
  cpu_proc_model i_cpu_proc_model (.clk_i(clk_i), .dev_data_i(dout), .dev_oe_i(oe),
    .cs_n_o(cs_n), .addr_o(addr), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(bus));
  cpu_fifo_port #(.RX_DEPTH(16)) i_cpu_fifo_port (.clk_i(clk_i), .resetn_i(resetn_i),
    .cs_n_i(cs_n), .port_address_bit_i(addr), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .cpu_data_bus_i(bus), .cpu_data_bus_o(dout), .cpu_data_bus_oe_o(oe),
    .send_now_wake_n_i(snw), .cpu_fifo_mode_i(mode), .remote_wake_en_i(rwe),
    .power_enable_n_i(pe_n), .mode_active_o(act), .resume_req_o(rsm), .flush_o(fl),
    .bulk_in_req_i(bulk), .usb_tx_valid_i(tx_v), .usb_tx_data_i(tx_d),
    .usb_tx_ready_o(tx_rdy), .usb_rx_valid_o(rx_v), .usb_rx_data_o(rx_d),
    .usb_rx_pop_i(pop), .rx_level_o(lvl));

  // Note bus ownership and count resume pulses
  always @(posedge clk_i)
  begin
    if (oe === 1'b1) seen_oe <= 1'b1;
    if (rsm === 1'b1) resumes <= resumes + 1;
  end
  // ----------------------------------
  // Helpers
  // ----------------------------------
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // Expected status byte from its field positions
  function automatic logic [7:0] exp_status(input logic txa, input logic rxf,
                                            input logic flp, input logic md);
    exp_status                    = 8'h00;
    exp_status[`CFP_STAT_TXAVAIL] = txa;
    exp_status[`CFP_STAT_RXFULL]  = rxf;
    exp_status[`CFP_STAT_FLUSH]   = flp;
    exp_status[`CFP_STAT_MODE]    = md;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task offer(input logic [7:0] v);
    int k;
    k = 0;
    tx_v = 1'b1;
    tx_d = v;
    while (tx_rdy !== 1'b1 && k < 50)
    begin
      cyc(1);
      k++;
    end
    cyc(1);
    tx_v = 1'b0;
    chk(tx_rdy === 1'b0, "host byte not held");
  endtask
  task do_reset(input logic m);
    resetn_i = 1'b0;
    mode = m;
    cyc(12);
    resetn_i = 1'b1;
    cyc(4);
  endtask
  task test_done;
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    // Scenarios need under a thousand cycles; allow twenty thousand
    #500000;
    failures++;
    test_done;
  end
  // ----------------------------------
  // Scenarios
  // ----------------------------------
  initial
  begin
    void'($urandom(51170));
    do_reset(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      offer(d);
      if (i == 0)
      begin
        i_cpu_proc_model.access(0, 0, 1, 8'h00, 4, q);
        chk(q === exp_status(1'b1, 1'b0, 1'b0, 1'b1), "status with host byte");
      end
      i_cpu_proc_model.access(0, 0, 0, 8'h00, 4 + $urandom % 5, q);
      chk(q === d, "read byte");
    end
    i_cpu_proc_model.access(0, 0, 0, 8'h00, 5, q);
    chk(q === 8'h00, "empty read");
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      i_cpu_proc_model.access(1, i == 2, i == 4, d, 4 + $urandom % 5, q);
      if (i != 2 && i != 4) exp_q.push_back(d);
    end
    cyc(4);
    chk(lvl === 5'(exp_q.size() - 1), "rx level");
    while (exp_q.size() > 0)
    begin
      d = exp_q.pop_front();
      chk(rx_v === 1'b1 && rx_d === d, "rx byte");
      pop = 1'b1;
      cyc(1);
      pop = 1'b0;
      cyc(1);
    end
    chk(rx_v === 1'b0, "dropped writes stored");
    for (int k = 0; k < 3; k++)
    begin
      pe_n = (k != 2);
      rwe = (k == 0);
      r0 = resumes;
      snw = 1'b0;
      cyc(4);
      snw = 1'b1;
      cyc(6);
      chk(resumes == r0 + (k == 0), "resume count");
      chk(fl === (k == 2), "flush set");
      i_cpu_proc_model.access(0, 0, 1, 8'h00, 4, q);
      chk(q === exp_status(1'b0, 1'b0, k == 2, 1'b1), "status flush bit");
      bulk = 1'b1;
      cyc(1);
      bulk = 1'b0;
      cyc(2);
      chk(fl === 1'b0, "flush clear");
    end
    do_reset(1'b0);
    seen_oe = 1'b0;
    i_cpu_proc_model.access(0, 0, 0, 8'h00, 5, q);
    i_cpu_proc_model.access(1, 0, 0, 8'h5a, 5, q);
    cyc(4);
    chk(seen_oe === 1'b0 && act === 1'b0 && rx_v === 1'b0, "mode off");
    test_done;
  end
endmodule // cpu_fifo_port_bench
